/* inc/cpm_pkg.sv */
// Package of register offsets, field layouts, reset values and timing counts for clock control.
package cpm_pkg;

    // Operating modes.
    typedef enum logic [1:0] {
        CPM_MODE_DIRECT = 2'h0,
        CPM_MODE_RUN    = 2'h1,
        CPM_MODE_STOP   = 2'h2
    } cpm_mode_type;

    // Register byte offsets.
    localparam logic [7:0] CPM_OFS_MODE    = 8'h00;
    localparam logic [7:0] CPM_OFS_SRC     = 8'h04;
    localparam logic [7:0] CPM_OFS_MAINPLL = 8'h08;
    localparam logic [7:0] CPM_OFS_USBPLL  = 8'h0C;
    localparam logic [7:0] CPM_OFS_GATE    = 8'h10;
    localparam logic [7:0] CPM_OFS_RESET   = 8'h14;
    localparam logic [7:0] CPM_OFS_STATUS  = 8'h18;

    // Field positions in the source register.
    localparam int CPM_SRC_MAIN_IN_BIT  = 0;
    localparam int CPM_SRC_OSC_OFF_BIT  = 1;
    localparam int CPM_SRC_USB_EN_BIT   = 2;
    // Field positions in a PLL register: N-1 [1:0], M-1 [9:2], post code [12:10], bypass [13].
    localparam int CPM_PLL_N_LSB   = 0;
    localparam int CPM_PLL_M_LSB   = 2;
    localparam int CPM_PLL_P_LSB   = 10;
    localparam int CPM_PLL_BYP_BIT = 13;
    localparam int CPM_PLL_EN_BIT  = 14;
    // Reset register: bit0 external pulse enable, [15:8] pulse length, bit31 watchdog flag.
    localparam int CPM_RST_EXT_BIT   = 0;
    localparam int CPM_RST_LEN_LSB   = 8;
    localparam int CPM_RST_FLAG_BIT  = 31;

    // Reset values.
    localparam logic [31:0] CPM_RST_PLL   = 32'h0000_0000;
    localparam logic [31:0] CPM_RST_GATE  = 32'hFFFF_FFFF;
    localparam logic [7:0]  CPM_RST_PULSE = 8'h10;

    // Fixed RTC multiplier factor.
    localparam logic [8:0] CPM_RTC_MULT = 9'h18D;
    localparam int CPM_GATE_W   = 16;
    localparam int CPM_USB_GATE = 15;

    // Internal watchdog reset length, in clock pulses.
    localparam int CPM_WDT_RST_CLKS = 10;
    localparam logic [3:0] CPM_WDT_RST_CNT = 4'(CPM_WDT_RST_CLKS);

    localparam logic [1:0] CPM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CPM_RESP_SLVERR = 2'h2;
endpackage

/* test/cpm_clock_power_mode_control_tb.sv */
// Self-checking testbench for the clock and power-mode control block.
module cpm_clock_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} cpm_row_type;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req, fire;
    logic        awready, wready, bvalid, arready, rvalid, wdt_req;
    logic        cpu_en, ahb_en, osc_en, src_rtc, run_sel, int_rst_n, rst_pin_n;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, data, main_cfg, usb_cfg;
    logic [15:0] idle, pclk_en;
    logic [8:0]  rtc_mult;
    logic [21:0] rst_outs;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n1, n2;
    // Register rows: offset, written word, expected read word, expected response.
    // The first main PLL row fills the N and M fields and sets post code 4, with bypass clear and the PLL left off.
    // The PLL words that stay enabled assume a 12 MHz oscillator.
    // Main: 240 MHz, bypassed. USB: 192 MHz, divided by four to 48 MHz.
    cpm_row_type rows [5] = '{'{8'h08, 32'h0000_13FF, 32'h0000_13FF, 2'h0},
        '{8'h08, 32'h0000_604C, 32'h0000_604C, 2'h0}, '{8'h0C, 32'h0000_483C, 32'h0000_483C, 2'h0},
        '{8'h04, 32'h0000_0001, 32'h0000_0001, 2'h0}, '{8'h1C, 32'h0000_1234, 32'h0000_0000, 2'h2}};

    cpm_clock_power_mode_control u_cpm_clock_power_mode_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wdt_reset_req(wdt_req), .wake_req(wake_req), .periph_idle(idle), .cpu_clk_en(cpu_en),
        .ahb_clk_en(ahb_en), .periph_clk_en(pclk_en), .main_osc_en(osc_en),
        .main_pll_src_rtc(src_rtc), .run_pll_sel(run_sel), .main_pll_cfg(main_cfg),
        .usb_pll_cfg(usb_cfg), .rtc_mult_factor(rtc_mult), .internal_reset_n(int_rst_n),
        .reset_output_pin_n(rst_pin_n));
    cpm_wdt_model u_cpm_wdt_model (.aclk(aclk), .fire(fire), .wdt_reset_req(wdt_req));
    // Outputs whose reset state is checked together after every release of reset.
    assign rst_outs = {cpu_en, ahb_en, osc_en, run_sel, int_rst_n, rst_pin_n, pclk_en};

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Address and data are offered together and each is dropped at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        data = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    // Free-running block clock at 250 MHz.
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    // A hang would otherwise never reach the verdict, so a cycle ceiling forces it.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done();
        end
    end
    // Main sequence: reset, register table, then modes, gating, oscillator and watchdog.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req, fire} = 8'h00;
        {awaddr, araddr, wdata, idle} = 64'h0000_0000_0000_0000;
        // The modelled oscillator is stable from time zero.
        // No start-up wait is needed before the reset pulse.
        tick(4);
        aresetn <= 1'h1;
        tick(1);
        chk("reset_outs", 32'h003B_FFFF, rst_outs);
        chk("rtc_mult", 32'h0000_018D, rtc_mult);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("wr_resp", rows[i].r, resp);
            rd(rows[i].a);
            chk("rd_resp", rows[i].r, resp);
            chk("rd_data", rows[i].q, data);
        end
        chk("main_cfg", 32'h0000_604C, main_cfg);
        chk("usb_cfg", 32'h0000_483C, usb_cfg);
        chk("src_rtc", 32'h0000_0001, src_rtc);
        wr(8'h00, 32'h0000_0001);
        tick(4);
        chk("run_sel", 32'h0000_0001, run_sel);
        wr(8'h00, 32'h0000_0002);
        tick(4);
        chk("stop_en", 32'h0000_8000, {cpu_en, ahb_en, pclk_en});
        wake_req <= 1'h1;
        tick(1);
        wake_req <= 1'h0;
        tick(4);
        chk("wake", 32'h0000_0006, {cpu_en, ahb_en, run_sel});
        // A reserved mode code is dropped, so the mode and the request both stay Direct Run.
        wr(8'h00, 32'h0000_0003);
        rd(8'h00);
        chk("mode_rsvd", 32'h0000_0000, data);
        wr(8'h10, 32'h0000_8005);
        tick(3);
        chk("gate", 32'h0000_8005, pclk_en);
        wr(8'h10, 32'hFFFF_FFFF);
        idle <= 16'h0002;
        // One idle edge keeps bready from being lowered and raised in one time step.
        tick(1);
        wr(8'h18, 32'h0000_0002);
        tick(3);
        chk("auto_gate", 32'h0000_FFFD, pclk_en);
        wr(8'h04, 32'h0000_0006);
        tick(3);
        chk("osc_usb", 32'h0000_0001, osc_en);
        wr(8'h04, 32'h0000_0002);
        tick(3);
        chk("osc_off", 32'h0000_0000, osc_en);
        wr(8'h14, 32'h0000_1001);
        fire <= 1'h1;
        tick(1);
        fire <= 1'h0;
        n1 = 0;
        n2 = 0;
        repeat (40) begin
            @(posedge aclk);
            n1 += (int_rst_n === 1'h0);
            n2 += (rst_pin_n === 1'h0);
        end
        chk("int_rst_ge10", 32'h0000_0001, 32'(n1 >= 10));
        chk("pin_len", 32'h0000_000F, 32'(n2));
        // The watchdog flag outlives its own pulse and clears only when a one is written.
        rd(8'h14);
        chk("wdt_flag", 32'h8000_1001, data);
        wr(8'h14, 32'h8000_1001);
        rd(8'h14);
        chk("flag_clr", 32'h0000_1001, data);
        // A reset in mid-run restores every default.
        // It starts from Run mode with the oscillator off.
        wr(8'h00, 32'h0000_0001);
        tick(4);
        aresetn <= 1'h0;
        tick(10);
        aresetn <= 1'h1;
        tick(1);
        chk("rst_again", 32'h003B_FFFF, rst_outs);
        rd(8'h00);
        chk("rst_mode", 32'h0000_0000, data);
        tick(1);
        rd(8'h14);
        chk("rst_cfg", 32'h0000_1000, data);
        test_done();
    end
endmodule

/* test/cpm_monitor.sv */
// Checker of mode, clock-enable and watchdog reset behaviour at the control block's ports.
module cpm_monitor (
    input logic       aclk,
    input logic       aresetn,
    input logic       s_axi_arvalid,
    input logic       s_axi_arready,
    input logic       s_axi_rvalid,
    input logic       wdt_reset_req,
    input logic       cpu_clk_en,
    input logic       ahb_clk_en,
    input logic [15:0] periph_clk_en,
    input logic       main_osc_en,
    input logic       run_pll_sel,
    input logic [8:0] rtc_mult_factor,
    input logic       internal_reset_n,
    input logic       reset_output_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // The clock enables, oscillator enable, PLL select and internal reset must show their reset state on the first edge after release.
    a_reset_defaults: assert property ($past(!aresetn) |-> cpu_clk_en && ahb_clk_en
        && (&periph_clk_en) && main_osc_en && !run_pll_sel && internal_reset_n)
        else $error("outputs not at reset state after release");
    a_rtc_factor: assert property (rtc_mult_factor == 9'h18D)
        else $error("rtc multiplier factor wrong");
    a_wdt_int_reset: assert property ($rose(wdt_reset_req) && internal_reset_n
        |=> (!internal_reset_n)[*8] ##1 (!internal_reset_n)[*2])
        else $error("internal reset shorter than ten cycles");
    a_pin_follows_wdt: assert property ($fell(reset_output_pin_n) |-> !internal_reset_n)
        else $error("reset output pin pulsed without watchdog reset");
    // A source switch must land inside a gap of the core clock enable, never under a live clock.
    a_switch_gap: assert property ($changed(run_pll_sel) |-> !(cpu_clk_en && $past(cpu_clk_en)))
        else $error("clock source switched while core clock enabled");
    a_cpu_ahb_pair: assert property (cpu_clk_en == ahb_clk_en)
        else $error("core and bus clock enables disagree");
    a_stop_usb_only: assert property ((!cpu_clk_en)[*3] |-> periph_clk_en[14:0] == 15'h0000)
        else $error("peripheral clock running in stop");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid && s_axi_arready)
        else $error("read not answered in one cycle");
    cover property ($rose(wdt_reset_req));
    cover property ((!cpu_clk_en)[*3]);
    cover property (!reset_output_pin_n);
endmodule
bind cpm_clock_power_mode_control cpm_monitor u_cpm_monitor (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .wdt_reset_req(wdt_reset_req), .cpu_clk_en(cpu_clk_en), .ahb_clk_en(ahb_clk_en),
    .periph_clk_en(periph_clk_en), .main_osc_en(main_osc_en), .run_pll_sel(run_pll_sel),
    .rtc_mult_factor(rtc_mult_factor), .internal_reset_n(internal_reset_n),
    .reset_output_pin_n(reset_output_pin_n));

/* test/cpm_wdt_model.sv */
// Watchdog stand-in that raises a device reset request for the clock control block.
module cpm_wdt_model (
    input  logic aclk,
    input  logic fire,
    output logic wdt_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // A real watchdog match is synchronous to the block clock, so the request is registered.
    always_ff @(posedge aclk) begin
        wdt_reset_req <= fire;
    end
endmodule

/* verilog/cpm_clock_power_mode_control.sv */
// Clock and power-mode control: mode machine, PLL settings, clock gates, reset sequencing.
module cpm_clock_power_mode_control (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        wdt_reset_req,
    input  wire logic        wake_req,
    input  wire logic [15:0] periph_idle,
    output logic             cpu_clk_en,
    output logic             ahb_clk_en,
    output logic [15:0]      periph_clk_en,
    output logic             main_osc_en,
    output logic             main_pll_src_rtc,
    output logic             run_pll_sel,
    output logic [31:0]      main_pll_cfg,
    output logic [31:0]      usb_pll_cfg,
    output logic [8:0]       rtc_mult_factor,
    output logic             internal_reset_n,
    output logic             reset_output_pin_n
);

    // Register state.
    cpm_pkg::cpm_mode_type mode_q;
    cpm_pkg::cpm_mode_type mode_req_q;
    logic [31:0] src_q;
    logic [31:0] main_pll_q;
    logic [31:0] usb_pll_q;
    logic [31:0] gate_q;
    logic [31:0] auto_q;
    logic [31:0] rst_cfg_q;
    logic        wdt_flag_q;
    logic [3:0]  int_rst_cnt_q;
    logic [7:0]  ext_rst_cnt_q;
    logic        sel_stable_q;

    // AXI slave state.
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic        wr_hit;
    logic [31:0] wmask;

    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_hit  = (awaddr_q == cpm_pkg::CPM_OFS_MODE) || (awaddr_q == cpm_pkg::CPM_OFS_SRC)
                  || (awaddr_q == cpm_pkg::CPM_OFS_MAINPLL)
                  || (awaddr_q == cpm_pkg::CPM_OFS_USBPLL)
                  || (awaddr_q == cpm_pkg::CPM_OFS_GATE)
                  || (awaddr_q == cpm_pkg::CPM_OFS_RESET)
                  || (awaddr_q == cpm_pkg::CPM_OFS_STATUS);

    // Write address and data are captured independently, in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_hold_q && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_hold_q     <= 1'b1;
                awaddr_q      <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold_q && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_hold_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cpm_pkg::CPM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? cpm_pkg::CPM_RESP_OKAY : cpm_pkg::CPM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers; reset returns every setting to its default.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_req_q <= cpm_pkg::CPM_MODE_DIRECT;
            src_q      <= 32'h0000_0000;
            main_pll_q <= cpm_pkg::CPM_RST_PLL;
            usb_pll_q  <= cpm_pkg::CPM_RST_PLL;
            gate_q     <= cpm_pkg::CPM_RST_GATE;
            auto_q     <= 32'h0000_0000;
            rst_cfg_q  <= {16'h0000, cpm_pkg::CPM_RST_PULSE, 8'h00};
        end else begin
            if (wr_fire && wstrb_q[0] && awaddr_q == cpm_pkg::CPM_OFS_MODE) begin
                // A reserved code is ignored so the machine keeps one of three modes.
                case (wdata_q[1:0])
                    2'h0:    mode_req_q <= cpm_pkg::CPM_MODE_DIRECT;
                    2'h1:    mode_req_q <= cpm_pkg::CPM_MODE_RUN;
                    2'h2:    mode_req_q <= cpm_pkg::CPM_MODE_STOP;
                    default: mode_req_q <= mode_req_q;
                endcase
            end else if (mode_q == cpm_pkg::CPM_MODE_STOP && wake_req) begin
                mode_req_q <= cpm_pkg::CPM_MODE_DIRECT;
            end
            if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_SRC) begin
                src_q <= (src_q & ~wmask) | (wdata_q & wmask & 32'h0000_0007);
            end
            if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_MAINPLL) begin
                main_pll_q <= (main_pll_q & ~wmask) | (wdata_q & wmask & 32'h0000_7FFF);
            end
            if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_USBPLL) begin
                usb_pll_q <= (usb_pll_q & ~wmask) | (wdata_q & wmask & 32'h0000_7FFF);
            end
            if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_GATE) begin
                gate_q <= (gate_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_STATUS) begin
                auto_q <= (auto_q & ~wmask) | (wdata_q & wmask & 32'h0000_FFFF);
            end
            if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_RESET) begin
                rst_cfg_q <= (rst_cfg_q & ~wmask) | (wdata_q & wmask & 32'h0000_FF01);
            end
        end
    end

    // Mode changes wait one cycle with all CPU and bus gates shut so no clock pulse is cut short.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q       <= cpm_pkg::CPM_MODE_DIRECT;
            sel_stable_q <= 1'b1;
        end else if (mode_req_q != mode_q && sel_stable_q) begin
            sel_stable_q <= 1'b0;
        end else if (!sel_stable_q) begin
            mode_q       <= mode_req_q;
            sel_stable_q <= 1'b1;
        end
    end

    // Clock enables follow the mode, except the USB gate (bit 15); the CPU and bus enables are held off while the select is not stable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en    <= 1'b1;
            ahb_clk_en    <= 1'b1;
            periph_clk_en <= cpm_pkg::CPM_RST_GATE[15:0];
            run_pll_sel   <= 1'b0;
        end else begin
            cpu_clk_en  <= sel_stable_q && mode_q != cpm_pkg::CPM_MODE_STOP;
            ahb_clk_en  <= sel_stable_q && mode_q != cpm_pkg::CPM_MODE_STOP;
            run_pll_sel <= mode_q == cpm_pkg::CPM_MODE_RUN;
            for (int i = 0; i < cpm_pkg::CPM_GATE_W; i++) begin
                if (i == cpm_pkg::CPM_USB_GATE) begin
                    periph_clk_en[i] <= gate_q[i];
                end else begin
                    periph_clk_en[i] <= gate_q[i] && !(auto_q[i] && periph_idle[i])
                                     && mode_q != cpm_pkg::CPM_MODE_STOP;
                end
            end
        end
    end

    // PLL settings driven out to the analog macros.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_pll_src_rtc <= 1'b0;
            main_osc_en      <= 1'b1;
            main_pll_cfg     <= cpm_pkg::CPM_RST_PLL;
            usb_pll_cfg      <= cpm_pkg::CPM_RST_PLL;
            rtc_mult_factor  <= cpm_pkg::CPM_RTC_MULT;
        end else begin
            main_pll_src_rtc <= src_q[cpm_pkg::CPM_SRC_MAIN_IN_BIT];
            main_osc_en      <= !src_q[cpm_pkg::CPM_SRC_OSC_OFF_BIT]
                             || src_q[cpm_pkg::CPM_SRC_USB_EN_BIT];
            main_pll_cfg     <= main_pll_q;
            usb_pll_cfg      <= usb_pll_q;
            rtc_mult_factor  <= cpm_pkg::CPM_RTC_MULT;
        end
    end

    // Watchdog reset: internal pulse of fixed length, optional external pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_rst_cnt_q      <= 4'h0;
            ext_rst_cnt_q      <= 8'h00;
            internal_reset_n   <= 1'b1;
            reset_output_pin_n <= 1'b1;
        end else begin
            if (wdt_reset_req && int_rst_cnt_q == 4'h0) begin
                int_rst_cnt_q <= cpm_pkg::CPM_WDT_RST_CNT;
            end else if (int_rst_cnt_q != 4'h0) begin
                int_rst_cnt_q <= int_rst_cnt_q - 4'h1;
            end
            internal_reset_n <= !(wdt_reset_req || int_rst_cnt_q > 4'h1);
            if (wdt_reset_req && rst_cfg_q[cpm_pkg::CPM_RST_EXT_BIT] && ext_rst_cnt_q == 8'h00) begin
                ext_rst_cnt_q <= rst_cfg_q[cpm_pkg::CPM_RST_LEN_LSB +: 8];
            end else if (ext_rst_cnt_q != 8'h00) begin
                ext_rst_cnt_q <= ext_rst_cnt_q - 8'h01;
            end
            reset_output_pin_n <= !(ext_rst_cnt_q > 8'h01);
        end
    end

    // Watchdog flag: set wins over a software clear; it survives the internal reset pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_flag_q <= 1'b0;
        end else if (wdt_reset_req) begin
            wdt_flag_q <= 1'b1;
        end else if (wr_fire && awaddr_q == cpm_pkg::CPM_OFS_RESET && wstrb_q[3]
                     && wdata_q[cpm_pkg::CPM_RST_FLAG_BIT]) begin
            wdt_flag_q <= 1'b0;
        end
    end

    // Read channel: answer in the same cycle as the address is taken, one cycle after the request.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= cpm_pkg::CPM_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= cpm_pkg::CPM_RESP_OKAY;
                case ({s_axi_araddr[7:2], 2'b00})
                    cpm_pkg::CPM_OFS_MODE:    s_axi_rdata <= {28'h000_0000, mode_q, mode_req_q};
                    cpm_pkg::CPM_OFS_SRC:     s_axi_rdata <= src_q;
                    cpm_pkg::CPM_OFS_MAINPLL: s_axi_rdata <= main_pll_q;
                    cpm_pkg::CPM_OFS_USBPLL:  s_axi_rdata <= usb_pll_q;
                    cpm_pkg::CPM_OFS_GATE:    s_axi_rdata <= gate_q;
                    cpm_pkg::CPM_OFS_RESET:   s_axi_rdata <= {wdt_flag_q, rst_cfg_q[30:0]};
                    cpm_pkg::CPM_OFS_STATUS:  s_axi_rdata <= {periph_clk_en, auto_q[15:0]};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= cpm_pkg::CPM_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule
